// File: src/fsynth_pkg.sv
// constants shared by the frequency synthesiser control block
// assumes a 32-bit ahb-lite bus with one register per aligned word
package fsynth_pkg;

   // phase sum is 24 bits wide, of which the low 20 take part in adding
   localparam int SUM_W   = 24;
   localparam int USED_W  = 20;
   localparam int STEP_W  = 20;
   localparam int WIDTH_W = 8;   // pulse length counter, up to 128 periods

   // number of selectable source clocks (codes 0 to 10)
   localparam int NUM_SOURCES = 11;
   localparam int SEL_W       = 4;

   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_SUM_LOW   = 12'h058C;
   localparam logic [11:0] IDX_SUM_HIGH  = 12'h058D;
   localparam logic [11:0] IDX_SUM_UPPER = 12'h058E;
   localparam logic [11:0] IDX_STEP_LOW  = 12'h058F;
   localparam logic [11:0] IDX_STEP_HIGH = 12'h0590;
   localparam logic [11:0] IDX_STEP_UPPR = 12'h0591;
   localparam logic [11:0] IDX_CONTROL   = 12'h0592;
   localparam logic [11:0] IDX_CLK_CTRL  = 12'h0593;

   // oscillator_control bit positions
   localparam int CON_EN_BIT   = 7;
   localparam int CON_OUT_BIT  = 5;
   localparam int CON_INV_BIT  = 4;
   localparam int CON_MODE_BIT = 0;

   // source_clock_control field positions
   localparam int CLK_PWS_LSB = 5;
   localparam int CLK_CKS_LSB = 0;

   // values after reset
   localparam logic [7:0]  RESET_BYTE = 8'h00;
   localparam logic [19:0] RESET_STEP = 20'h0_0000;
   localparam logic [19:0] RESET_SUM  = 20'h0_0000;

   // ahb transfer type carrying a request
   localparam logic [1:0] TRANS_NONSEQ = 2'h2;

endpackage

// File: src/source_sync.sv
// synchronises the candidate source clocks and flags edges of the chosen one
// assumes the source inputs are asynchronous to hclk and slower than hclk / 2
module source_sync
   import fsynth_pkg::*;
#(
   parameter int N = NUM_SOURCES
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [N-1:0]     src_in,
   input  wire logic [SEL_W-1:0] sel,
   output logic                  rise,
   output logic                  fall
);

   logic [N-1:0] stage1;   // first flop, read only by stage2
   logic [N-1:0] stage2;   // settled copies
   logic         chosen_q; // previous level of the chosen source
   logic         chosen;   // selected settled level

   // two flops per source clock
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_sync
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               stage1[i] <= 1'b0;
               stage2[i] <= 1'b0;
            end else begin
               stage1[i] <= src_in[i];
               stage2[i] <= stage1[i];
            end
         end
      end
   endgenerate

   // reserved codes select a quiet source
   assign chosen = (sel < SEL_W'(N)) ? stage2[sel] : 1'b0;

   // history for edge detection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) chosen_q <= 1'b0;
      else          chosen_q <= chosen;
   end

   assign rise = chosen & ~chosen_q;
   assign fall = ~chosen & chosen_q;

endmodule

// File: src/frequency_synth_ctrl.sv
// numerically controlled oscillator with its byte registers on ahb-lite
// assumes one ahb-lite master, single word transfers, source clocks slow
// against hclk so that each source edge is seen after synchronisation
//
// Contract
// - 24-bit phase sum as three bytes
// - sum runs on source ticks, no atomicity
// - each tick adds 20-bit step to sum
// - step as three bytes, upper holds 19:16
// - working copy loads on falling edge after low write
// - bit 7 enables oscillator, resets clear
// - bit 5 reads present output, read-only
// - bit 4 inverts the output
// - bit 0 picks pulse or half-rate toggle
// - width field gives 2^n period pulses
// - bits 3:0 select source, high codes reserved
// - width ignored in fixed-duty mode
//
// The AHB-Lite slave port is this design's own decision.
module frequency_synth_ctrl
   import fsynth_pkg::*;
(
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic [31:0]                 hrdata,
   output logic                        hresp,
   input  wire logic [NUM_SOURCES-1:0] src_clk,
   output logic                        freq_out
);

   // ---------------------------------------------------------------
   // bus side state
   // ---------------------------------------------------------------
   logic [11:0]        wr_index;      // index of the pending write
   logic               wr_pending;    // write data arrives this cycle
   logic [11:0]        rd_index;      // index of the pending read
   logic               rd_wait;       // read takes one wait state

   // ---------------------------------------------------------------
   // software visible registers
   // ---------------------------------------------------------------
   logic [3:0]         step_upper_byte;      // step bits 19:16
   logic [7:0]         step_high_byte;       // step bits 15:8
   logic [7:0]         step_low_byte;        // step bits 7:0
   logic [STEP_W-1:0]  step_working_copy;    // copy used by the adder
   logic               load_pending;         // low byte written, not loaded
   logic               enable;               // oscillator running
   logic               output_invert;        // invert final output
   logic               pulse_mode_select;    // pulse train when set
   logic [2:0]         pulse_width_select;   // pulse length exponent
   logic [SEL_W-1:0]   source_clock_select;  // source code

   // ---------------------------------------------------------------
   // oscillator core state
   // ---------------------------------------------------------------
   logic [USED_W-1:0]  phase_sum;     // working part of the sum
   logic               raw_out;       // output before inversion
   logic [WIDTH_W-1:0] width_cnt;     // periods left in a pulse

   // ---------------------------------------------------------------
   // decode wires
   // ---------------------------------------------------------------
   logic               req;           // valid transfer in address phase
   logic               wr_req;        // write request taken
   logic               rd_req;        // read request taken
   logic [11:0]        req_index;     // word index of the request
   logic               addr_in_page;  // upper address bits are zero
   logic               wr_data;       // write data cycle
   logic               wr_sum_l;      // write strobes per register
   logic               wr_sum_h;
   logic               wr_sum_u;
   logic               wr_step_l;
   logic               wr_step_h;
   logic               wr_step_u;
   logic               wr_con;
   logic               wr_clk;
   logic [7:0]         wbyte;         // low byte of write data
   logic [7:0]         con_view;      // control register as read
   logic [7:0]         clk_view;      // clock register as read
   logic [SUM_W-1:0]   sum_view;      // 24-bit view of the phase sum
   logic [7:0]         rd_byte;       // selected read byte

   // ---------------------------------------------------------------
   // oscillator wires
   // ---------------------------------------------------------------
   logic               tick;          // rising edge of chosen source
   logic               fall_edge;     // falling edge of chosen source
   logic               advance;       // tick while running
   logic [USED_W:0]    sum_plus;      // sum with carry
   logic               overflow;      // carry out of the 20-bit range
   logic [WIDTH_W-1:0] pulse_len;     // periods minus one
   logic               next_raw;      // raw output after this cycle
   logic [WIDTH_W-1:0] next_width;    // counter after this cycle

   // ---------------------------------------------------------------
   // source clock synchronisation
   // ---------------------------------------------------------------
   source_sync #(
      .N       (NUM_SOURCES)
   ) u_source_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .src_in  (src_clk),
      .sel     (source_clock_select),
      .rise    (tick),
      .fall    (fall_edge)
   );

   // ---------------------------------------------------------------
   // address phase decode
   // ---------------------------------------------------------------
   assign req          = hsel & hready & (htrans == TRANS_NONSEQ);
   assign wr_req       = req & hwrite;
   assign rd_req       = req & ~hwrite;
   assign req_index    = haddr[13:2];
   assign addr_in_page = (haddr[31:14] == 18'h0_0000);

   // capture the address of a write for its data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending <= 1'b0;
         wr_index   <= 12'h000;
      end else begin
         wr_pending <= wr_req & addr_in_page;
         wr_index   <= req_index;
      end
   end

   // capture a read; the wait state lets a write just before settle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_wait  <= 1'b0;
         rd_index <= 12'h000;
      end else begin
         rd_wait  <= rd_req;
         rd_index <= addr_in_page ? req_index : 12'hFFF;
      end
   end

   // ready drops for the one wait cycle of a read
   assign hreadyout = ~rd_wait;
   // every transfer is answered okay
   assign hresp     = 1'b0;

   // ---------------------------------------------------------------
   // write strobes
   // ---------------------------------------------------------------
   assign wr_data   = wr_pending;
   assign wbyte     = hwdata[7:0];
   assign wr_sum_l  = wr_data & (wr_index == IDX_SUM_LOW);
   assign wr_sum_h  = wr_data & (wr_index == IDX_SUM_HIGH);
   assign wr_sum_u  = wr_data & (wr_index == IDX_SUM_UPPER);
   assign wr_step_l = wr_data & (wr_index == IDX_STEP_LOW);
   assign wr_step_h = wr_data & (wr_index == IDX_STEP_HIGH);
   assign wr_step_u = wr_data & (wr_index == IDX_STEP_UPPR);
   assign wr_con    = wr_data & (wr_index == IDX_CONTROL);
   assign wr_clk    = wr_data & (wr_index == IDX_CLK_CTRL);

   // ---------------------------------------------------------------
   // step bytes
   // ---------------------------------------------------------------
   // step byte registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         step_upper_byte <= RESET_STEP[19:16];
         step_high_byte  <= RESET_STEP[15:8];
         step_low_byte   <= RESET_STEP[7:0];
      end else begin
         if (wr_step_u) step_upper_byte <= wbyte[3:0];
         if (wr_step_h) step_high_byte  <= wbyte;
         if (wr_step_l) step_low_byte   <= wbyte;
      end
   end

   // buffered copy load
   // a low byte write arms the load; a new write wins over clearing it on a falling edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         load_pending <= 1'b0;
      end else if (wr_step_l) begin
         load_pending <= 1'b1;
      end else if (fall_edge) begin
         load_pending <= 1'b0;
      end
   end

   // copy taken on source falling edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         step_working_copy <= RESET_STEP;
      end else if (load_pending && fall_edge) begin
         step_working_copy <= {step_upper_byte, step_high_byte, step_low_byte};
      end
   end

   // ---------------------------------------------------------------
   // control and clock registers
   // ---------------------------------------------------------------
   // enable bit, inversion, mode
   // the output level bit is not written
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable            <= RESET_BYTE[CON_EN_BIT];
         output_invert     <= RESET_BYTE[CON_INV_BIT];
         pulse_mode_select <= RESET_BYTE[CON_MODE_BIT];
      end else if (wr_con) begin
         enable            <= wbyte[CON_EN_BIT];
         output_invert     <= wbyte[CON_INV_BIT];
         pulse_mode_select <= wbyte[CON_MODE_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse_width_select  <= RESET_BYTE[CLK_PWS_LSB +: 3];
         source_clock_select <= RESET_BYTE[CLK_CKS_LSB +: SEL_W];
      end else if (wr_clk) begin
         pulse_width_select  <= wbyte[CLK_PWS_LSB +: 3];
         source_clock_select <= wbyte[CLK_CKS_LSB +: SEL_W];
      end
   end

   // ---------------------------------------------------------------
   // phase accumulation
   // ---------------------------------------------------------------
   // no advance while disabled
   assign advance  = enable & tick;
   assign sum_plus = {1'b0, phase_sum} + {1'b0, step_working_copy};
   // carry out is the output event
   assign overflow = advance & sum_plus[USED_W];

   // sum follows source ticks, bytes read independently
   // a bus write wins; writing while running is left undefined
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_sum <= RESET_SUM;
      end else if (wr_sum_u) begin
         phase_sum[19:16] <= wbyte[3:0];
      end else if (wr_sum_h) begin
         phase_sum[15:8] <= wbyte;
      end else if (wr_sum_l) begin
         phase_sum[7:0] <= wbyte;
      end else if (advance) begin
         phase_sum <= sum_plus[USED_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // output shaping
   // ---------------------------------------------------------------
   // pulse lasts 2^n ticks, so count 2^n - 1 more
   assign pulse_len = WIDTH_W'((9'h001 << pulse_width_select) - 9'h001);

   // next raw level and pulse counter
   always_comb begin
      next_raw   = raw_out;
      next_width = width_cnt;
      if (!enable) begin
         next_raw   = 1'b0;
         next_width = '0;
      end else if (!pulse_mode_select) begin
         next_width = '0;
         if (overflow) next_raw = ~raw_out;
      end else if (overflow) begin
         next_raw   = 1'b1;
         next_width = pulse_len;
      end else if (tick && raw_out) begin
         if (width_cnt == '0) begin
            next_raw = 1'b0;
         end else begin
            next_width = width_cnt - WIDTH_W'(1);
         end
      end
   end

   // raw level and counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         raw_out   <= 1'b0;
         width_cnt <= '0;
      end else begin
         raw_out   <= next_raw;
         width_cnt <= next_width;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) freq_out <= 1'b0;
      else          freq_out <= next_raw ^ (wr_con ? wbyte[CON_INV_BIT] : output_invert);
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   // output level shown read-only
   assign con_view = {enable, 1'b0, freq_out, output_invert, 3'h0, pulse_mode_select};
   assign clk_view = {pulse_width_select, 1'b0, source_clock_select};
   // upper nibble of the sum reads zero
   assign sum_view = {{(SUM_W - USED_W){1'b0}}, phase_sum};

   // read byte selection; unmapped words read zero
   assign rd_byte =
      (rd_index == IDX_SUM_LOW)   ? sum_view[7:0]   :
      (rd_index == IDX_SUM_HIGH)  ? sum_view[15:8]  :
      (rd_index == IDX_SUM_UPPER) ? sum_view[23:16] :
      (rd_index == IDX_STEP_LOW)  ? step_low_byte   :
      (rd_index == IDX_STEP_HIGH) ? step_high_byte  :
      (rd_index == IDX_STEP_UPPR) ? {4'h0, step_upper_byte} :
      (rd_index == IDX_CONTROL)   ? con_view :
      (rd_index == IDX_CLK_CTRL)  ? clk_view : 8'h00;

   // read data loaded during the wait state, held afterwards
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)     hrdata <= 32'h0000_0000;
      else if (rd_wait) hrdata <= {24'h00_0000, rd_byte};
   end

   // hsize is accepted but only whole words are expected
   logic unused_size;
   assign unused_size = ^hsize;

endmodule

// File: bench/frequency_synth_ctrl_assertions.sv
// concurrent checks for the synthesiser control block, bound to its ports
// assumes hready is looped back from hreadyout and source phases last 10 hclk
module fsynth_checker
   import fsynth_pkg::*;
(
   input wire logic                   hclk,
   input wire logic                   hresetn,
   input wire logic                   hsel,
   input wire logic [31:0]            haddr,
   input wire logic [1:0]             htrans,
   input wire logic                   hwrite,
   input wire logic [2:0]             hsize,
   input wire logic [31:0]            hwdata,
   input wire logic                   hready,
   input wire logic                   hreadyout,
   input wire logic [31:0]            hrdata,
   input wire logic                   hresp,
   input wire logic [NUM_SOURCES-1:0] src_clk,
   input wire logic                   freq_out
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic        ph_v;      // a data phase is open
   logic        ph_wr;     // open phase is a write
   logic        ph_map;    // upper address bits were zero
   logic [11:0] ph_idx;    // word index of open phase
   logic [7:0]  ctl;       // shadow of oscillator_control
   logic [7:0]  clk_sel;   // shadow of source_clock_control
   logic        src_prev;  // selected source one cycle ago
   logic [3:0]  tick_age;  // cycles since the selected source rose
   logic [3:0]  cfg_age;   // cycles since a control or clock write
   wire logic take    = hsel && hready && (htrans == TRANS_NONSEQ);
   wire logic wr_done = ph_v && ph_wr && hready;
   wire logic rd_done = ph_v && !ph_wr && hready;
   wire logic cfg_wr  = wr_done && ph_map && (ph_idx == IDX_CONTROL || ph_idx == IDX_CLK_CTRL);
   wire logic unmap   = !ph_map || ph_idx < IDX_SUM_LOW || ph_idx > IDX_CLK_CTRL;
   wire logic sel_src = (clk_sel[3:0] < 4'hB) ? src_clk[clk_sel[3:0]] : 1'b0;
   // track bus phases, register shadows and source edge age
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_v <= 1'b0; ph_wr <= 1'b0; ph_map <= 1'b0; ph_idx <= 12'h000;
         ctl <= 8'h00; clk_sel <= 8'h00; src_prev <= 1'b0;
         tick_age <= 4'hF; cfg_age <= 4'h0;
      end else begin
         if (take) begin
            ph_v <= 1'b1; ph_wr <= hwrite; ph_idx <= haddr[13:2];
            ph_map <= (haddr[31:14] == 18'h0_0000);
         end else if (hready) ph_v <= 1'b0;
         if (cfg_wr && ph_idx == IDX_CONTROL) ctl <= hwdata[7:0];
         if (cfg_wr && ph_idx == IDX_CLK_CTRL) clk_sel <= hwdata[7:0];
         src_prev <= sel_src;
         if (sel_src && !src_prev) tick_age <= 4'h0;
         else if (tick_age != 4'hF) tick_age <= tick_age + 4'h1;
         if (cfg_wr) cfg_age <= 4'h0;
         else if (cfg_age != 4'hF) cfg_age <= cfg_age + 4'h1;
      end
   end
   sequence s_read_addr;
      take && !hwrite;
   endsequence
   sequence s_one_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   a_read_one_wait: assert property (s_read_addr |=> s_one_wait)
      else $error("read did not take exactly one wait state");
   a_write_no_wait: assert property (take && hwrite |=> hreadyout)
      else $error("write data phase was stretched");
   a_resp_always_okay: assert property (hresp == 1'b0)
      else $error("slave gave a non okay response");
   a_rdata_byte_only: assert property (rd_done |-> hrdata[31:8] == 24'h00_0000)
      else $error("read data carried bits above the byte");
   a_unmapped_zero: assert property (rd_done && unmap |-> hrdata == 32'h0000_0000)
      else $error("unmapped read returned nonzero data");
   a_sum_upper_nibble: assert property (rd_done && !unmap && ph_idx == IDX_SUM_UPPER
      |-> hrdata[7:4] == 4'h0)
      else $error("unused sum bits read nonzero");
   a_ctl_readback: assert property (rd_done && !unmap && ph_idx == IDX_CONTROL
      && cfg_age > 4'h2 |-> hrdata[7] == ctl[7] && hrdata[4] == ctl[4] && hrdata[0] == ctl[0])
      else $error("control bits read back wrong");
   a_out_readback: assert property (rd_done && !unmap && ph_idx == IDX_CONTROL
      && $stable(freq_out) && $past(freq_out, 3) == freq_out |-> hrdata[5] == freq_out)
      else $error("output level bit differs from the output");
   a_off_level: assert property (!ctl[7] && cfg_age > 4'h2 |-> freq_out == ctl[4])
      else $error("disabled output not at its inverted idle level");
   a_out_on_tick: assert property (ctl[7] && cfg_age > 4'h2 && $changed(freq_out)
      |-> tick_age >= 4'h1 && tick_age <= 4'h7)
      else $error("output moved away from a source tick");
endmodule

bind frequency_synth_ctrl fsynth_checker chk_i (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .src_clk(src_clk),
   .freq_out(freq_out)
);

// File: bench/frequency_synth_ctrl_tb_top.sv
// self-checking bench for the synthesiser control block
// assumes the bus loops hreadyout back to hready; sources run 10 hclk per phase
module frequency_synth_ctrl_tb_top
   import fsynth_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic                   hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, freq_out;
   logic [31:0]            haddr, hwdata, hrdata;
   logic [1:0]             htrans;
   logic [2:0]             hsize;
   logic [NUM_SOURCES-1:0] src_clk;
   int                     error_cnt, checks, cyc;
   assign hready = hreadyout;
   frequency_synth_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .src_clk(src_clk),
      .freq_out(freq_out));
   // bus clock, 100 ns period
   always #50 hclk = ~hclk;
   // cut a hang short
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (error_cnt == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
      checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask
   // one single ahb-lite transfer, held until hready is sampled high
   task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1; htrans <= TRANS_NONSEQ; hwrite <= w; haddr <= {18'h0_0000, idx, 2'h0};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h00_0000, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      logic [31:0] unused;
      bus(1'b1, idx, d, unused);
   endtask
   task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp, input string what);
      logic [31:0] rd;
      bus(1'b0, idx, 8'h00, rd);
      chk({24'h00_0000, exp}, rd, what);
   endtask
   // run whole periods on one source line, or all lines for a reserved code
   task automatic src_run(input logic [3:0] code, input int n);
      logic [NUM_SOURCES-1:0] m;
      m = (code < 4'hB) ? (11'h001 << code) : '1;
      repeat (n) begin
         @(posedge hclk); src_clk <= m;
         repeat (10) @(posedge hclk);
         src_clk <= '0;
         repeat (9) @(posedge hclk);
      end
   endtask
   task automatic sum_set(input logic [19:0] v);
      wr(IDX_SUM_LOW, v[7:0]); wr(IDX_SUM_HIGH, v[15:8]); wr(IDX_SUM_UPPER, {4'h0, v[19:16]});
   endtask
   // upper and high bytes go first so the low write arms a whole value
   task automatic step_set(input logic [19:0] v);
      wr(IDX_STEP_UPPR, {4'h0, v[19:16]}); wr(IDX_STEP_HIGH, v[15:8]); wr(IDX_STEP_LOW, v[7:0]);
   endtask
   task automatic sum_chk(input logic [19:0] v);
      rd_chk(IDX_SUM_LOW, v[7:0], "sum low"); rd_chk(IDX_SUM_HIGH, v[15:8], "sum high");
      rd_chk(IDX_SUM_UPPER, {4'h0, v[19:16]}, "sum upper");
   endtask
   // reset values of every register, and an unmapped word
   task automatic t_reset_map();
      for (logic [11:0] i = IDX_SUM_LOW; i <= IDX_CLK_CTRL; i++) rd_chk(i, RESET_BYTE, "reset");
      wr(12'h0594, 8'h5A);
      rd_chk(12'h0594, 8'h00, "unmapped");
   endtask
   // byte access, unused bits, read-only output bit and inversion while off
   task automatic t_reg_access();
      wr(IDX_SUM_UPPER, 8'hFF); rd_chk(IDX_SUM_UPPER, 8'h0F, "sum upper");
      wr(IDX_STEP_UPPR, 8'hFF); rd_chk(IDX_STEP_UPPR, 8'h0F, "step upper");
      wr(IDX_STEP_HIGH, 8'hA5); rd_chk(IDX_STEP_HIGH, 8'hA5, "step high");
      wr(IDX_STEP_LOW, 8'h3C); rd_chk(IDX_STEP_LOW, 8'h3C, "step low");
      wr(IDX_CLK_CTRL, 8'hEF); rd_chk(IDX_CLK_CTRL, 8'hEF, "clock reg");
      wr(IDX_CONTROL, 8'h20); rd_chk(IDX_CONTROL, 8'h00, "output bit");
      wr(IDX_CONTROL, 8'h11); repeat (3) @(posedge hclk);
      rd_chk(IDX_CONTROL, 8'h31, "inverted idle");
      chk(32'h0000_0001, {31'h0, freq_out}, "inverted out");
      wr(IDX_CONTROL, 8'h00);
   endtask
   // half-step gives an overflow every second tick, toggled out, for every source
   task automatic t_fixed_duty();
      int tg;
      logic prev;
      for (int c = 0; c < NUM_SOURCES; c++) begin
         wr(IDX_CONTROL, 8'h00); sum_set(20'h0_0000); step_set(20'h8_0000);
         wr(IDX_CLK_CTRL, 8'hE0 | 8'(c));
         src_run(4'(c), 1);
         wr(IDX_CONTROL, 8'h80);
         tg = 0; prev = freq_out;
         repeat (7) begin
            src_run(4'(c), 1);
            if (freq_out !== prev) tg++;
            prev = freq_out;
         end
         chk(32'h0000_0003, 32'(tg), "toggles");
         wr(IDX_CONTROL, 8'h00);
         sum_chk(20'h8_0000);
      end
   endtask
   // one overflow starts a pulse whose length is counted in source periods
   task automatic t_pulse();
      int hi;
      for (int n = 0; n < 8; n++) begin
         wr(IDX_CONTROL, 8'h00); sum_set(20'hF_FFFF); step_set(20'h0_0001);
         wr(IDX_CLK_CTRL, {3'(n), 5'h03});
         src_run(4'h3, 1);
         wr(IDX_CONTROL, 8'h81);
         hi = 0;
         repeat ((1 << n) + 3) begin
            src_run(4'h3, 1);
            if (freq_out === 1'b1) hi++;
         end
         chk(32'(1 << n), 32'(hi), "pulse length");
         wr(IDX_CONTROL, 8'h00);
         sum_chk(20'((1 << n) + 2));
      end
   endtask
   // a reserved source code gives no ticks even with every line running
   task automatic t_reserved();
      sum_set(20'h0_0000); step_set(20'h1_2345);
      wr(IDX_CLK_CTRL, 8'h0B); wr(IDX_CONTROL, 8'h80);
      src_run(4'hB, 4);
      wr(IDX_CONTROL, 8'h00);
      sum_chk(20'h0_0000);
      chk(32'h0000_0000, {31'h0, freq_out}, "idle out");
   endtask
   // reset, then the scenarios in turn
   initial begin
      hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'h0;
      hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0000_0000; src_clk = '0;
      error_cnt = 0; checks = 0; cyc = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset_map();
      t_reg_access();
      t_fixed_duty();
      t_pulse();
      t_reserved();
      complete_run();
   end
endmodule
